// ===== sewp_if.sv
// Two-wire link between the EEPROM slave end and its master end.
// Open-drain wires are resolved here from the output enables.
`timescale 1ns/10ps
interface sewp_if;
	// Clock line, driven by master only
	logic scl_o;
	logic scl_oe_n;
	// Data line, both ends pull low
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	// Write protect
	logic write_protect_input;
	// Resolved wire levels (pull-up)
	wire scl = scl_oe_n ? 1'b1 : scl_o;
	wire sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
	modport slave (input scl, input sda, input write_protect_input,
		output sda_s_o, output sda_s_oe_n);
	modport master (input scl, input sda, output scl_o, output scl_oe_n,
		output sda_m_o, output sda_m_oe_n, output write_protect_input);
endinterface

// ===== sewp_master.sv
// Master end: divides its clock to make the bus clock, writes one byte.
// Assumes the user issues single byte writes only when ready is high.
`timescale 1ns/10ps
module sewp_master
	import sewp_pkg::*;
(
	// Link
	sewp_if.master bus,
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// User request
	input wire logic req,
	input wire logic fast_mode,
	input wire logic [2:0] dev_addr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic protect,
	// User answer
	output logic ready_q,
	output logic nack_q
);
	typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP, MS_DONE} sewp_ms_t;
	sewp_ms_t ms_q;
	logic [26:0] shift_q;
	logic [4:0] nbit_q;
	logic [1:0] ph_q;
	logic [7:0] div_q;
	logic scl_o_q, sda_o_q, wp_q;
	logic s1_q, s2_q;
	// Rate chosen per request; low supply requires standard
	logic fast_q;
	wire [7:0] half = fast_q ? 8'(FAST_HALF) : 8'(STD_HALF);
	wire tick = div_q == 8'h00;
	assign bus.scl_o = scl_o_q;
	assign bus.scl_oe_n = scl_o_q;
	assign bus.sda_m_o = sda_o_q;
	assign bus.sda_m_oe_n = sda_o_q;
	assign bus.write_protect_input = wp_q;

	////////////////////////////////////////////////////////////////
	// Sync of sampled data line
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else begin
			s1_q <= bus.sda;
			s2_q <= s1_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Quarter-bit phases: data changes with clock low, sampled high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ms_q <= MS_IDLE;
			shift_q <= 27'h0;
			nbit_q <= 5'h0;
			ph_q <= 2'h0;
			div_q <= 8'h00;
			scl_o_q <= 1'b1;
			sda_o_q <= 1'b1;
			wp_q <= 1'b0;
			fast_q <= 1'b0;
			ready_q <= 1'b1;
			nack_q <= 1'b0;
		end else begin
			div_q <= tick ? half : div_q - 8'h01;
			// Protect held low unless user asks to cancel
			wp_q <= protect;
			case (ms_q)
				MS_IDLE: if (req && ready_q) begin
					ready_q <= 1'b0;
					nack_q <= 1'b0;
					fast_q <= fast_mode;
					shift_q <= {DEV_TYPE, dev_addr, 1'b0, 1'b1,
						addr, 1'b1, wdata, 1'b1};
					nbit_q <= 5'd27;
					ms_q <= MS_START;
					ph_q <= 2'h0;
				end
				MS_START: if (tick) begin
					sda_o_q <= 1'b0;
					ms_q <= MS_BIT;
				end
				MS_BIT: if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: scl_o_q <= 1'b0;
						2'h1: sda_o_q <= shift_q[26];
						2'h2: scl_o_q <= 1'b1;
						default: begin
							if (nbit_q == 5'd19 || nbit_q == 5'd10 ||
								nbit_q == 5'd1)
								nack_q <= nack_q | s2_q;
							shift_q <= {shift_q[25:0], 1'b1};
							nbit_q <= nbit_q - 5'h1;
							if (nbit_q == 5'h1)
								ms_q <= MS_STOP;
						end
					endcase
				end
				MS_STOP: if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: scl_o_q <= 1'b0;
						2'h1: sda_o_q <= 1'b0;
						2'h2: scl_o_q <= 1'b1;
						default: begin
							sda_o_q <= 1'b1;
							ms_q <= MS_DONE;
						end
					endcase
				end
				MS_DONE: begin
					ready_q <= 1'b1;
					ms_q <= MS_IDLE;
				end
				default: ms_q <= MS_IDLE;
			endcase
		end
	end
endmodule

// ===== sewp_monitor.sv
// Concurrent checks on the two-wire link between slave and master ends.
// Assumes it is instantiated beside the interface, sampled on master clk.
`timescale 1ns/10ps
module sewp_monitor
	import sewp_pkg::*;
#(
	parameter int WRITE_TICKS_P = WRITE_TICKS
) (
	// Master clock domain
	input wire logic clk,
	input wire logic reset_n,
	// Link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe_n,
	input wire logic write_protect_input,
	// Slave status
	input wire logic busy_q,
	input wire logic abort_q
);
	localparam logic [15:0] MIN_PER = 16'(CLK_HZ / FAST_RATE_HZ);
	localparam int BUSY_MAX = (WRITE_TICKS_P + 4) * (CLK_HZ / TICK_HZ);
	localparam logic [15:0] BUSY_LIM = 16'(BUSY_MAX);
	logic scl_q;
	logic sda_q;
	logic stop_seen_q;
	logic [15:0] busy_cnt_q;
	logic [15:0] per_cnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	// Bus conditions decoded from two samples of the wires
	wire stop_w = scl && scl_q && sda && !sda_q;
	wire start_w = scl && scl_q && !sda && sda_q;
	wire rise_w = scl && !scl_q;

	// Helper counters; period saturates so idle gaps never wrap
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			stop_seen_q <= 1'b0;
			busy_cnt_q <= 16'h0000;
			per_cnt_q <= 16'hFFFF;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			stop_seen_q <= stop_w ? 1'b1 : (start_w ? 1'b0 : stop_seen_q);
			busy_cnt_q <= busy_q ? busy_cnt_q + 16'h0001 : 16'h0000;
			per_cnt_q <= rise_w ? 16'h0001 :
				(&per_cnt_q ? per_cnt_q : per_cnt_q + 16'h0001);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Properties
	property p_drive_on_low;
		$changed(sda_s_oe_n) |-> !scl;
	endproperty
	property p_quiet_busy;
		busy_q |-> sda_s_oe_n;
	endproperty
	property p_abort_stop;
		$rose(write_protect_input) && busy_q |-> ##[1:80] !busy_q;
	endproperty
	property p_abort_flag;
		$rose(write_protect_input) && busy_q |-> ##[1:80] abort_q;
	endproperty
	property p_write_bound;
		busy_cnt_q <= BUSY_LIM;
	endproperty
	property p_after_stop;
		$rose(busy_q) |-> stop_seen_q;
	endproperty
	property p_cancel;
		$rose(busy_q) |-> !write_protect_input;
	endproperty
	property p_idle_after_abort;
		$rose(abort_q) |=> sda_s_oe_n [*8];
	endproperty
	property p_scl_rate;
		$rose(scl) |-> per_cnt_q >= MIN_PER;
	endproperty

	a_drive_on_low: assert property (p_drive_on_low)
		else $error("slave data drive changed while clock high");
	a_quiet_busy: assert property (p_quiet_busy)
		else $error("slave drove data while programming");
	a_abort_stop: assert property (p_abort_stop)
		else $error("programming not stopped by protect");
	a_abort_flag: assert property (p_abort_flag)
		else $error("abort flag not set by protect");
	a_write_bound: assert property (p_write_bound)
		else $error("programming ran past its time limit");
	a_after_stop: assert property (p_after_stop)
		else $error("programming began without a stop");
	a_cancel: assert property (p_cancel)
		else $error("programming began with protect high");
	a_idle_after_abort: assert property (p_idle_after_abort)
		else $error("slave drove data after abort");
	a_scl_rate: assert property (p_scl_rate)
		else $error("clock period shorter than fast rate");

	// Main scenarios reached
	c_write: cover property ($rose(busy_q));
	c_abort: cover property ($rose(abort_q));
	c_stop: cover property (stop_w && !busy_q);
endmodule

// ===== sewp_pkg.sv
// Shared constants for the serial EEPROM write-protect link.
// Assumes a 25 MHz system clock at the master end and a filter-clocked slave.
package sewp_pkg;
	// Master system clock
	localparam int CLK_HZ = 25000000;
	// Bus rates in Hz
	localparam int STD_RATE_HZ = 100000;
	localparam int FAST_RATE_HZ = 400000;
	// Divider half periods for the master clock generator
	localparam int STD_HALF = CLK_HZ / (2 * STD_RATE_HZ);
	localparam int FAST_HALF = (CLK_HZ + 2 * FAST_RATE_HZ - 1) / (2 * FAST_RATE_HZ);
	// Glitch filter width in ns and in master cycles (least time, round up)
	localparam int GLITCH_FILTER_WIDTH_NS = 100;
	localparam int GLITCH_CYC = (GLITCH_FILTER_WIDTH_NS * 25 + 999) / 1000;
	// Internal write time in ms
	localparam int INTERNAL_WRITE_TIME_MS = 5;
	// Slave counts it on a free 1 MHz timebase input
	localparam int TICK_HZ = 1000000;
	localparam int WRITE_TICKS = INTERNAL_WRITE_TIME_MS * (TICK_HZ / 1000);
	// Device type nibble on the bus
	localparam logic [3:0] DEV_TYPE = 4'hA;
	// Byte width
	localparam int BYTE_W = 8;
endpackage

// ===== sewp_slave.sv
// Contract
// - Sample data on rising clock edge
// - Drive data from falling clock edge
// - Both speeds behave the same
// - Master keeps 100kHz at low supply (master has no supply input; rate follows fast_mode per request)
// - Reject pulses shorter than filter width
// - Programming ends within 5 ms
// - Master holds protect low through write
// - Protect high before programming cancels write
// - Protect high during programming aborts it
// - Program only after stop past full byte
// - Ignore commands while programming
// - Commands start with start condition
// Slave end: bus logic clocked by the filter clock, acting on sampled link clock edges.
// Assumes a 1 MHz free timebase and a glitch-filtered sample clock.
`timescale 1ns/10ps
module sewp_slave
	import sewp_pkg::*;
#(
	parameter int WRITE_TICKS_P = WRITE_TICKS,
	parameter int DEPTH = 256
) (
	// Link
	sewp_if.slave bus,
	// Filter and timer clocks, reset
	input wire logic filt_clk,
	input wire logic tick_clk,
	input wire logic reset_n,
	// Device address straps
	input wire logic [2:0] dev_addr,
	// Status to user
	output logic busy_q,
	output logic [7:0] last_byte_q,
	output logic abort_q
);
	typedef enum {ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_RDATA, ST_ACK,
		ST_RACK, ST_SKIP} sewp_st_t;
	sewp_st_t st_q, ret_q;
	logic [7:0] mem [DEPTH];
	logic [7:0] sh_q, addr_q, wdata_q;
	logic [3:0] bit_q;
	logic rd_q, have_byte_q;
	logic scl_f1_q, scl_f2_q, sda_f1_q, sda_f2_q, scl_q, sda_q;
	logic [3:0] scl_cnt_q, sda_cnt_q;

	////////////////////////////////////////////////////////////////
	// Two-flop sync then persistence count, pulses below filter width dropped
	always_ff @(posedge filt_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_f1_q <= 1'b1;
			scl_f2_q <= 1'b1;
			sda_f1_q <= 1'b1;
			sda_f2_q <= 1'b1;
		end else begin
			scl_f1_q <= bus.scl;
			scl_f2_q <= scl_f1_q;
			sda_f1_q <= bus.sda;
			sda_f2_q <= sda_f1_q;
		end
	end
	wire scl_diff = scl_f2_q != scl_q;
	wire sda_diff = sda_f2_q != sda_q;
	// Level changes only after it persists GLITCH_CYC cycles
	always_ff @(posedge filt_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_cnt_q <= 4'h0;
			sda_cnt_q <= 4'h0;
		end else begin
			scl_cnt_q <= scl_diff ? scl_cnt_q + 4'h1 : 4'h0;
			sda_cnt_q <= sda_diff ? sda_cnt_q + 4'h1 : 4'h0;
			if (scl_diff && scl_cnt_q >= 4'(GLITCH_CYC - 1))
				scl_q <= scl_f2_q;
			if (sda_diff && sda_cnt_q >= 4'(GLITCH_CYC - 1))
				sda_q <= sda_f2_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Start and stop detection on data edges while clock high
	logic sda_d1_q, start_tg_q, stop_tg_q;
	always_ff @(posedge filt_clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_d1_q <= 1'b1;
			start_tg_q <= 1'b0;
			stop_tg_q <= 1'b0;
		end else begin
			sda_d1_q <= sda_q;
			if (scl_q && sda_d1_q && !sda_q)
				start_tg_q <= ~start_tg_q;
			if (scl_q && !sda_d1_q && sda_q)
				stop_tg_q <= ~stop_tg_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Write timer on tick clock; request/abort cross by toggle
	logic go_tg_q, done_tg_q, wp_s1_q, wp_s2_q, go_s1_q, go_s2_q, go_s3_q;
	logic run_q, wp_t1_q, wp_t2_q, abt_tg_q;
	logic [15:0] tmr_q;
	always_ff @(posedge tick_clk or negedge reset_n) begin
		if (!reset_n) begin
			go_s1_q <= 1'b0;
			go_s2_q <= 1'b0;
			go_s3_q <= 1'b0;
			wp_t1_q <= 1'b0;
			wp_t2_q <= 1'b0;
			run_q <= 1'b0;
			tmr_q <= 16'h0000;
			done_tg_q <= 1'b0;
			abt_tg_q <= 1'b0;
		end else begin
			go_s1_q <= go_tg_q;
			go_s2_q <= go_s1_q;
			go_s3_q <= go_s2_q;
			wp_t1_q <= bus.write_protect_input;
			wp_t2_q <= wp_t1_q;
			if (go_s2_q != go_s3_q) begin
				run_q <= 1'b1;
				tmr_q <= 16'h0000;
			end else if (run_q && wp_t2_q) begin
				run_q <= 1'b0; // Abort at once
				abt_tg_q <= ~abt_tg_q;
				done_tg_q <= ~done_tg_q;
			end else if (run_q && tmr_q >= 16'(WRITE_TICKS_P - 1)) begin
				run_q <= 1'b0; // Bounded cycle
				done_tg_q <= ~done_tg_q;
			end else if (run_q)
				tmr_q <= tmr_q + 16'h0001;
		end
	end
	// Memory cells written at end of an unaborted cycle
	logic [7:0] pa_q, pd_q;
	always_ff @(posedge tick_clk) begin
		if (run_q && !wp_t2_q && tmr_q >= 16'(WRITE_TICKS_P - 1))
			mem[pa_q] <= pd_q;
	end

	////////////////////////////////////////////////////////////////
	// Filter clock domain protocol engine; writes pend until stop
	logic dn_s1_q, dn_s2_q, dn_s3_q, st_s1_q, st_s2_q, st_s3_q;
	logic sp_s1_q, sp_s2_q, sp_s3_q, ab_s1_q, ab_s2_q, ab_s3_q;
	logic wpb1_q, wpb2_q;
	always_ff @(posedge filt_clk or negedge reset_n) begin
		if (!reset_n) begin
			{dn_s1_q, dn_s2_q, dn_s3_q} <= 3'h0;
			{st_s1_q, st_s2_q, st_s3_q} <= 3'h0;
			{sp_s1_q, sp_s2_q, sp_s3_q} <= 3'h0;
			{ab_s1_q, ab_s2_q, ab_s3_q} <= 3'h0;
			{wpb1_q, wpb2_q} <= 2'h0;
		end else begin
			{dn_s1_q, dn_s2_q, dn_s3_q} <= {done_tg_q, dn_s1_q, dn_s2_q};
			{st_s1_q, st_s2_q, st_s3_q} <= {start_tg_q, st_s1_q, st_s2_q};
			{sp_s1_q, sp_s2_q, sp_s3_q} <= {stop_tg_q, sp_s1_q, sp_s2_q};
			{ab_s1_q, ab_s2_q, ab_s3_q} <= {abt_tg_q, ab_s1_q, ab_s2_q};
			{wpb1_q, wpb2_q} <= {bus.write_protect_input, wpb1_q};
		end
	end
	// Start/stop reach the protocol engine as pulses on the filter clock
	wire start_p = st_s2_q != st_s3_q;
	wire stop_p = sp_s2_q != sp_s3_q;
	wire done_p = dn_s2_q != dn_s3_q;
	wire abt_p = ab_s2_q != ab_s3_q;
	// Filtered clock edges drive the engine
	logic scl_d_q;
	always_ff @(posedge filt_clk or negedge reset_n) begin
		if (!reset_n)
			scl_d_q <= 1'b1;
		else
			scl_d_q <= scl_q;
	end
	wire rise = scl_q && !scl_d_q;
	wire fall = !scl_q && scl_d_q;
	wire addr_hit = sh_q[7:1] == {DEV_TYPE, dev_addr};
	wire [7:0] sh_next = {sh_q[6:0], sda_q};
	logic sda_oe_n_q, sda_o_q;
	assign bus.sda_s_o = sda_o_q;
	assign bus.sda_s_oe_n = sda_oe_n_q;

	// Engine; same behaviour at either bus rate
	always_ff @(posedge filt_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_IDLE;
			ret_q <= ST_IDLE;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			rd_q <= 1'b0;
			have_byte_q <= 1'b0;
			busy_q <= 1'b0;
			go_tg_q <= 1'b0;
			pa_q <= 8'h00;
			pd_q <= 8'h00;
			last_byte_q <= 8'h00;
			abort_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
			sda_o_q <= 1'b1;
		end else begin
			if (done_p)
				busy_q <= 1'b0;
			if (abt_p)
				abort_q <= 1'b1; // Location now undefined
			if (busy_q) begin
				st_q <= ST_IDLE;
				sda_oe_n_q <= 1'b1;
			end else if (have_byte_q && wpb2_q) begin
				have_byte_q <= 1'b0; // Cancel, memory untouched
				st_q <= ST_IDLE;
				sda_oe_n_q <= 1'b1;
			end else if (start_p) begin
				st_q <= ST_DEV;
				bit_q <= 4'h0;
				have_byte_q <= 1'b0;
				abort_q <= 1'b0;
				sda_oe_n_q <= 1'b1;
			end else if (stop_p) begin
				if (have_byte_q) begin
					busy_q <= 1'b1;
					go_tg_q <= ~go_tg_q;
					pa_q <= addr_q;
					pd_q <= wdata_q;
				end
				have_byte_q <= 1'b0;
				st_q <= ST_IDLE;
				sda_oe_n_q <= 1'b1;
			end else if (rise) begin
				case (st_q)
					ST_DEV, ST_WADDR, ST_WDATA: begin
						sh_q <= sh_next;
						bit_q <= bit_q + 4'h1;
					end
					ST_RACK: begin
						st_q <= sda_q ? ST_IDLE : ST_RDATA;
						bit_q <= 4'h0;
					end
					default: begin
					end
				endcase
			end else if (fall) begin
				// Data drives follow falling edges; start, stop, busy and a protect cancel release the line at once
				case (st_q)
					ST_DEV, ST_WADDR, ST_WDATA: begin
						if (bit_q == 4'h8) begin
							bit_q <= 4'h0;
							if (st_q == ST_DEV && !addr_hit)
								st_q <= ST_SKIP;
							else begin
								sda_oe_n_q <= 1'b0;
								sda_o_q <= 1'b0;
								ret_q <= st_q;
								rd_q <= st_q == ST_DEV && sh_q[0];
								st_q <= ST_ACK;
								if (st_q == ST_WADDR)
									addr_q <= sh_q;
								if (st_q == ST_WDATA) begin
									wdata_q <= sh_q;
									last_byte_q <= sh_q;
									have_byte_q <= 1'b1;
								end
							end
						end
					end
					ST_ACK: begin
						sda_oe_n_q <= 1'b1;
						if (ret_q == ST_DEV && rd_q) begin
							st_q <= ST_RDATA;
							sda_oe_n_q <= mem[addr_q][7]; // Release for a one
							sda_o_q <= mem[addr_q][7];
							bit_q <= 4'h1;
						end else
							st_q <= ret_q == ST_DEV ? ST_WADDR : ST_WDATA;
					end
					ST_RDATA: begin
						if (bit_q == 4'h8) begin
							sda_oe_n_q <= 1'b1;
							addr_q <= addr_q + 8'h01;
							st_q <= ST_RACK;
						end else begin
							sda_oe_n_q <= mem[addr_q][3'(7 - bit_q)];
							sda_o_q <= mem[addr_q][3'(7 - bit_q)];
							bit_q <= bit_q + 4'h1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule

// ===== tb_top.sv
// Self-checking bench joining slave and master ends through the interface.
// Assumes short write timer parameter; slave strapped to device address 5.
`timescale 1ns/10ps
module tb_top;
	import sewp_pkg::*;
	localparam int TICKS = 200;
	localparam int LIMIT = 95000;
	logic clk = 1'b0;
	logic filt_clk = 1'b0;
	logic tick_clk = 1'b0;
	logic reset_n = 1'b0;
	logic req = 1'b0;
	logic fast_mode = 1'b0;
	logic protect = 1'b0;
	logic [2:0] m_dev = 3'h5;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic ready_q;
	logic nack_q;
	logic busy_q;
	logic abort_q;
	logic [7:0] last_byte_q;
	logic saw_busy;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// Clocks; filter clock kept off the master's phase on purpose
	always #20 clk = ~clk;
	always #18 filt_clk = ~filt_clk;
	always #500 tick_clk = ~tick_clk;

	sewp_if bus ();
	sewp_slave #(.WRITE_TICKS_P(TICKS), .DEPTH(256)) sewp_slave_i (
		.bus(bus), .filt_clk(filt_clk), .tick_clk(tick_clk),
		.reset_n(reset_n), .dev_addr(3'h5), .busy_q(busy_q),
		.last_byte_q(last_byte_q), .abort_q(abort_q));
	sewp_master sewp_master_i (
		.bus(bus), .clk(clk), .reset_n(reset_n), .req(req),
		.fast_mode(fast_mode), .dev_addr(m_dev), .addr(addr),
		.wdata(wdata), .protect(protect), .ready_q(ready_q),
		.nack_q(nack_q));
	sewp_monitor #(.WRITE_TICKS_P(TICKS)) sewp_monitor_i (
		.clk(clk), .reset_n(reset_n), .scl(bus.scl), .sda(bus.sda),
		.sda_s_oe_n(bus.sda_s_oe_n),
		.write_protect_input(bus.write_protect_input),
		.busy_q(busy_q), .abort_q(abort_q));

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One byte write; req pulsed one cycle, bounded wait on ready
	task automatic write_byte(input logic [2:0] da, input logic [7:0] d,
		input logic fm, input logic prot);
		int n;
		@(negedge clk);
		m_dev = da;
		addr = d ^ 8'h3C;
		wdata = d;
		fast_mode = fm;
		protect = prot;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		n = 0;
		while (ready_q !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		check("ready", {7'h00, ready_q}, 8'h01);
	endtask

	task automatic wait_busy(input logic level, input int lim);
		int n;
		n = 0;
		while (busy_q !== level && n < lim) begin
			@(negedge clk);
			n++;
		end
		check("busy", {7'h00, busy_q}, {7'h00, level});
	endtask

	// Hang guard, reckoned from the longest expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			fail_count++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		repeat (60) @(negedge clk);
		// Fast write, programming starts after stop and ends in time
		write_byte(3'h5, 8'hA5, 1'b1, 1'b0);
		check("nack", {7'h00, nack_q}, 8'h00);
		check("last byte", last_byte_q, 8'hA5);
		wait_busy(1'b1, 200);
		wait_busy(1'b0, 6000);
		check("abort", {7'h00, abort_q}, 8'h00);
		// Standard rate behaves the same
		write_byte(3'h5, 8'h5A, 1'b0, 1'b0);
		check("nack", {7'h00, nack_q}, 8'h00);
		check("last byte", last_byte_q, 8'h5A);
		wait_busy(1'b1, 200);
		wait_busy(1'b0, 6000);
		// Other device address is not acknowledged
		write_byte(3'h2, 8'hE7, 1'b1, 1'b0);
		check("nack", {7'h00, nack_q}, 8'h01);
		check("last byte", last_byte_q, 8'h5A);
		// Back-to-back: second command lands during programming
		write_byte(3'h5, 8'hC3, 1'b1, 1'b0);
		write_byte(3'h5, 8'h3C, 1'b1, 1'b0);
		check("nack", {7'h00, nack_q}, 8'h01);
		check("last byte", last_byte_q, 8'hC3);
		wait_busy(1'b0, 6000);
		// Protect held high through the write cancels it
		write_byte(3'h5, 8'h77, 1'b1, 1'b1);
		saw_busy = 1'b0;
		repeat (300) begin
			@(negedge clk);
			if (busy_q !== 1'b0) saw_busy = 1'b1;
		end
		check("cancel busy", {7'h00, saw_busy}, 8'h00);
		protect = 1'b0;
		// Protect raised mid-programming aborts at once
		write_byte(3'h5, 8'h99, 1'b1, 1'b0);
		wait_busy(1'b1, 200);
		protect = 1'b1;
		wait_busy(1'b0, 100);
		check("abort", {7'h00, abort_q}, 8'h01);
		protect = 1'b0;
		// Next command after abort is accepted again
		repeat (10) @(negedge clk);
		write_byte(3'h5, 8'h42, 1'b1, 1'b0);
		check("nack", {7'h00, nack_q}, 8'h00);
		check("last byte", last_byte_q, 8'h42);
		wait_busy(1'b1, 200);
		wait_busy(1'b0, 6000);
		test_done();
	end
endmodule
